// [flash_pes.sv]
/*
  Program, erase and suspend sequencer of a serial flash device.
  The link half runs on the host's serial clock and captures each frame; the
  core half runs on ref_clk_i, judges the frame when chip select rises and
  times the self-timed operation. Protection and mode bits arrive as plain
  inputs on ref_clk_i; the array is driven through the arr_* outputs.
*/
`timescale 1ns/10ps

// How it works
// - Quad program is taken only while quad_enable is 1.
// - Quad program is 32h, then address and data on four IO lines.
// - One quad program writes one to 256 bytes into the array.
// - Program and erase need the write enable latch set first.
// - Chip select stays low for the whole program frame.
// - Opcode 20h with address erases that 4K sector.
// - Opcode 52h with address erases that 32K block.
// - Opcode D8h with address erases that 64K block.
// - Opcode C7h or 60h erases the whole array.
// - Erase address is 24 bits, or 32 bits in four-byte mode.
// - A frame that does not end on a byte boundary is dropped.
// - Chip select rising on a good frame starts the timed operation.
// - Busy is 1 for the whole timed cycle, then 0.
// - The write enable latch clears when a cycle completes.
// - Protected or locked targets are not programmed or erased.
// - Chip erase is refused if any region is protected.
// - Suspend needs suspend flag 0 and busy 1 on program or erase.
// - Suspend during chip erase is ignored.
// - Erase commands are refused while an erase is suspended.
// - Program commands are refused while a program is suspended.
// - Accepted suspend sets the flag at once, busy drops after latency.
// - Reset clears the suspend state and the suspend flag.
// - Program bytes past the page end wrap to the page start.
// - Resume clears the flag at once and sets busy within 200 ns.
module flash_pes
  import flash_pes_pkg::*;
#(
  parameter int PROG_CYCLES  = PAGE_PROG_US * REF_CYCLES_PER_US,
  parameter int SECT_CYCLES  = SECT_ERASE_US * REF_CYCLES_PER_US,
  parameter int BLK32_CYCLES = BLK32_ERASE_US * REF_CYCLES_PER_US,
  parameter int BLK64_CYCLES = BLK64_ERASE_US * REF_CYCLES_PER_US,
  parameter int CHIP_CYCLES  = CHIP_ERASE_US * REF_CYCLES_PER_US
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  spi_clk_i,
  input  wire logic                  cs_n_i,
  input  wire logic [3:0]            io_i,
  input  wire logic                  quad_enable_i,
  input  wire logic                  addr4_mode_i,
  input  wire logic                  protect_complement_i,
  input  wire logic                  protect_top_bottom_i,
  input  wire logic [3:0]            block_protect_i,
  input  wire logic [NUM_BLOCKS-1:0] block_lock_i,
  output logic                       busy_o,
  output logic                       write_enable_latch_o,
  output logic                       suspend_flag_o,
  output logic                       status_write_ok_o,
  output logic                       arr_we_o,
  output logic [31:0]                arr_addr_o,
  output logic [7:0]                 arr_wdata_o,
  output logic                       arr_erase_o,
  output logic [2:0]                 arr_erase_kind_o
);

  // ----------------------------------------------------------------
  // Link half: frame capture on the serial clock
  // ----------------------------------------------------------------
  logic        frame_q;
  logic [15:0] lcnt_q, lcnt_d, lcnt_now;
  logic [7:0]  lopc_q, lopc_d;
  logic [31:0] laddr_q, laddr_d;
  logic [3:0]  lnib_q, lnib_d;
  logic [7:0]  lidx_q, lidx_d, lidx_now;
  logic [8:0]  lnum_q, lnum_d, lnum_now;
  logic        lbusy_s1_q, lbusy_s2_q, la4_s1_q, la4_s2_q;
  logic [7:0]  page_q [PAGE_BYTES];
  logic        page_we;
  logic [7:0]  page_wa;
  logic [15:0] qaddr_end, ers_end;

  // Frame flag clears while chip select is high so the first edge restarts counts
  always_ff @(posedge spi_clk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      frame_q <= 1'b0;
    end else begin
      frame_q <= 1'b1;
    end
  end

  // Fields survive the end of frame for the core half; they restart on the next frame
  always_comb begin
    lcnt_now  = frame_q ? lcnt_q : 16'h0000;
    lidx_now  = frame_q ? lidx_q : 8'h00;
    lnum_now  = frame_q ? lnum_q : 9'h000;
    qaddr_end = la4_s2_q ? LEN_QADDR_A4 : LEN_QADDR_A3;
    ers_end   = la4_s2_q ? LEN_ERASE_A4 : LEN_ERASE_A3;
    lcnt_d    = (lcnt_now == LEN_MAX) ? LEN_MAX - 16'h0001 : lcnt_now + 16'h0001;
    lopc_d    = frame_q ? lopc_q : 8'h00;
    laddr_d   = frame_q ? laddr_q : 32'h0000_0000;
    lnib_d    = lnib_q;
    lidx_d    = lidx_now;
    lnum_d    = lnum_now;
    page_we   = 1'b0;
    page_wa   = laddr_q[7:0] + lidx_now;
    if (lcnt_now < LEN_OPCODE) begin
      lopc_d = {lopc_d[6:0], io_i[0]};
    end else if (lopc_q == OP_QUAD_PROG) begin
      if (lcnt_now < qaddr_end) begin
        laddr_d = {laddr_q[27:0], io_i};
      end else if (!lcnt_now[0]) begin
        lnib_d = io_i;                                       // High nibble first
      end else begin
        page_we = !lbusy_s2_q;
        lidx_d  = lidx_now + 8'h01;
        lnum_d  = (lnum_now == PAGE_FULL) ? PAGE_FULL : lnum_now + 9'h001;
      end
    end else if (lcnt_now < ers_end) begin
      laddr_d = {laddr_q[30:0], io_i[0]};
    end
  end

  // Link registers, with two-flop crossings of busy and address mode
  always_ff @(posedge spi_clk_i) begin
    lcnt_q     <= lcnt_d;
    lopc_q     <= lopc_d;
    laddr_q    <= laddr_d;
    lnib_q     <= lnib_d;
    lidx_q     <= lidx_d;
    lnum_q     <= lnum_d;
    lbusy_s1_q <= busy_o;
    lbusy_s2_q <= lbusy_s1_q;
    la4_s1_q   <= addr4_mode_i;
    la4_s2_q   <= la4_s1_q;
    if (page_we) begin
      page_q[page_wa] <= {lnib_q, io_i};
    end
  end

  // ----------------------------------------------------------------
  // Core half: command judgement and self-timed cycle
  // ----------------------------------------------------------------
  seq_state_t  st_q, st_d;
  op_kind_t    kind_q, kind_d, skind_q, skind_d;
  logic [31:0] tmr_q, tmr_d, stmr_q, stmr_d;
  logic [8:0]  widx_q, widx_d;
  logic        wel_q, wel_d, susp_q, susp_d, busy_q, busy_d, stw_q, stw_d;
  logic        awe_q, awe_d, aers_q, aers_d;
  logic [31:0] aaddr_q, aaddr_d;
  logic [7:0]  awd_q, awd_d;
  logic [2:0]  akind_q, akind_d;
  logic        cs_s1_q, cs_s2_q, cs_s3_q;
  logic        cs_rise, idle, esusp, psusp, clean_ers, clean_prog, cmd_ok;
  logic [31:0] taddr;
  logic [8:0]  tblk;
  logic [7:0]  woff;

  // Cycle length of each operation kind
  function automatic logic [31:0] dur(input op_kind_t k);
    case (k)
      K_SECTOR: dur = 32'(SECT_CYCLES);
      K_BLK32:  dur = 32'(BLK32_CYCLES);
      K_BLK64:  dur = 32'(BLK64_CYCLES);
      K_CHIP:   dur = 32'(CHIP_CYCLES);
      default:  dur = 32'(PROG_CYCLES);
    endcase
  endfunction

  // Number of 64K blocks covered by the block-protect field
  function automatic logic [9:0] bp_count(input logic [3:0] bp);
    if (bp == 4'h0) begin
      bp_count = 10'h000;
    end else if (bp >= BP_ALL_CODE) begin
      bp_count = BP_ALL;
    end else begin
      bp_count = 10'h001 << (bp - 4'h1);
    end
  endfunction

  // One block protected by the block-protect field or its own lock
  function automatic logic prot_hit(input logic [8:0] blk);
    logic [9:0] n;
    logic       inr;
    n        = bp_count(block_protect_i);
    inr      = protect_top_bottom_i ? ({1'b0, blk} < n) : ({1'b0, blk} >= BP_ALL - n);
    prot_hit = (inr ^ protect_complement_i) | block_lock_i[blk];
  endfunction

  // Any block protected anywhere in the array
  function automatic logic prot_any();
    logic [9:0] n;
    n        = bp_count(block_protect_i);
    prot_any = (protect_complement_i ? (n < BP_ALL) : (n != 10'h000)) | (|block_lock_i);
  endfunction

  // Chip select crossing; the second and third flops feed the edge detect
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= cs_n_i;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  // Frame judgement and sequencing
  always_comb begin
    cs_rise    = cs_s2_q & ~cs_s3_q;
    idle       = (st_q == ST_IDLE);
    esusp      = susp_q && (skind_q != K_PROG);
    psusp      = susp_q && (skind_q == K_PROG);
    taddr      = addr4_mode_i ? laddr_q : (laddr_q & MASK_ADDR3);
    tblk       = taddr[BLK_MSB:BLK_LSB];
    clean_ers  = (lcnt_q == (addr4_mode_i ? LEN_ERASE_A4 : LEN_ERASE_A3));
    clean_prog = (lcnt_q >= (addr4_mode_i ? LEN_QADDR_A4 : LEN_QADDR_A3) + 16'h0002)
                 && !lcnt_q[0];
    cmd_ok     = cs_rise && idle && wel_q;
    woff       = laddr_q[7:0] + widx_q[7:0];
    st_d       = st_q;
    kind_d     = kind_q;
    skind_d    = skind_q;
    tmr_d      = tmr_q;
    stmr_d     = stmr_q;
    widx_d     = widx_q;
    wel_d      = wel_q;
    susp_d     = susp_q;
    awe_d      = 1'b0;
    aers_d     = 1'b0;
    aaddr_d    = aaddr_q;
    awd_d      = awd_q;
    akind_d    = akind_q;
    if (cs_rise && idle && lcnt_q == LEN_OPCODE && lopc_q == OP_WR_EN) begin
      wel_d = 1'b1;
    end
    if (cs_rise && idle && lcnt_q == LEN_OPCODE && lopc_q == OP_WR_DIS) begin
      wel_d = 1'b0;
    end
    // Erase commands
    if (cmd_ok && clean_ers && !esusp) begin
      if (lopc_q == OP_SECT_ERS && !prot_hit(tblk)) begin
        kind_d  = K_SECTOR;
        aaddr_d = taddr & MASK_SECTOR;
      end else if (lopc_q == OP_BLK32_ERS && !prot_hit(tblk)) begin
        kind_d  = K_BLK32;
        aaddr_d = taddr & MASK_BLK32;
      end else if (lopc_q == OP_BLK64_ERS && !prot_hit(tblk)) begin
        kind_d  = K_BLK64;
        aaddr_d = taddr & MASK_BLK64;
      end
      if ((lopc_q == OP_SECT_ERS || lopc_q == OP_BLK32_ERS || lopc_q == OP_BLK64_ERS)
          && !prot_hit(tblk)) begin
        st_d    = ST_RUN;
        tmr_d   = dur(kind_d);
        aers_d  = 1'b1;
        akind_d = kind_d;
      end
    end
    if (cmd_ok && lcnt_q == LEN_OPCODE && !esusp && !prot_any()
        && (lopc_q == OP_CHIP_ERS1 || lopc_q == OP_CHIP_ERS2)) begin
      kind_d  = K_CHIP;
      st_d    = ST_RUN;
      tmr_d   = dur(K_CHIP);
      aers_d  = 1'b1;
      akind_d = K_CHIP;
      aaddr_d = 32'h0000_0000;
    end
    // Quad page program
    if (cmd_ok && clean_prog && lopc_q == OP_QUAD_PROG && quad_enable_i
        && !psusp && !prot_hit(tblk) && lnum_q != 9'h000) begin
      kind_d = K_PROG;
      st_d   = ST_WALK;
      widx_d = 9'h000;
    end
    // Suspend and resume
    if (cs_rise && lcnt_q == LEN_OPCODE && lopc_q == OP_SUSPEND && st_q == ST_RUN
        && !susp_q && kind_q != K_CHIP) begin
      susp_d  = 1'b1;
      skind_d = kind_q;
      stmr_d  = tmr_q;
      st_d    = ST_SUSPENDING;
      tmr_d   = 32'(SUSPEND_CYCLES - 1);
    end
    if (cs_rise && lcnt_q == LEN_OPCODE && lopc_q == OP_RESUME && idle && susp_q) begin
      susp_d = 1'b0;
      st_d   = ST_RESUMING;
      tmr_d  = 32'(RESUME_CYCLES - 1);
    end
    case (st_q)
      ST_WALK: begin
        awe_d   = 1'b1;
        aaddr_d = (taddr & MASK_PAGE) | {24'h00_0000, woff};
        awd_d   = page_q[woff];
        widx_d  = widx_q + 9'h001;
        if (widx_q + 9'h001 >= lnum_q) begin
          st_d  = ST_RUN;
          tmr_d = dur(K_PROG);
        end
      end
      ST_RUN: begin
        if (st_d == ST_RUN) begin
          if (tmr_q == 32'h0000_0000) begin
            st_d  = ST_IDLE;
            wel_d = 1'b0;
          end else begin
            tmr_d = tmr_q - 32'h0000_0001;
          end
        end
      end
      ST_SUSPENDING: begin
        if (tmr_q == 32'h0000_0000) begin
          st_d = ST_IDLE;
        end else begin
          tmr_d = tmr_q - 32'h0000_0001;
        end
      end
      ST_RESUMING: begin
        if (tmr_q == 32'h0000_0000) begin
          st_d   = ST_RUN;
          kind_d = skind_q;
          tmr_d  = stmr_q;
        end else begin
          tmr_d = tmr_q - 32'h0000_0001;
        end
      end
      default: begin
      end
    endcase
    busy_d = (st_d == ST_WALK) || (st_d == ST_RUN) || (st_d == ST_SUSPENDING);
    stw_d  = !susp_d;
  end

  // Core registers; reset also drops any suspended operation
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_q    <= ST_IDLE;
      kind_q  <= K_SECTOR;
      skind_q <= K_SECTOR;
      tmr_q   <= 32'h0000_0000;
      stmr_q  <= 32'h0000_0000;
      widx_q  <= 9'h000;
      wel_q   <= 1'b0;
      susp_q  <= 1'b0;
      busy_q  <= 1'b0;
      stw_q   <= 1'b1;
      awe_q   <= 1'b0;
      aers_q  <= 1'b0;
      aaddr_q <= 32'h0000_0000;
      awd_q   <= 8'h00;
      akind_q <= 3'h0;
    end else begin
      st_q    <= st_d;
      kind_q  <= kind_d;
      skind_q <= skind_d;
      tmr_q   <= tmr_d;
      stmr_q  <= stmr_d;
      widx_q  <= widx_d;
      wel_q   <= wel_d;
      susp_q  <= susp_d;
      busy_q  <= busy_d;
      stw_q   <= stw_d;
      awe_q   <= awe_d;
      aers_q  <= aers_d;
      aaddr_q <= aaddr_d;
      awd_q   <= awd_d;
      akind_q <= akind_d;
    end
  end

  // Outputs straight from flops
  assign busy_o               = busy_q;
  assign write_enable_latch_o = wel_q;
  assign suspend_flag_o       = susp_q;
  assign status_write_ok_o    = stw_q;
  assign arr_we_o             = awe_q;
  assign arr_addr_o           = aaddr_q;
  assign arr_wdata_o          = awd_q;
  assign arr_erase_o          = aers_q;
  assign arr_erase_kind_o     = akind_q;

endmodule

// [flash_pes_pkg.sv]
/*
  Shared constants and types for the flash program, erase and suspend sequencer.
  Assumes a 256 Mbit array of 512 blocks of 64K bytes and a 40 MHz reference clock.
*/
package flash_pes_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WR_EN     = 8'h06;
  localparam logic [7:0] OP_WR_DIS    = 8'h04;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_SECT_ERS  = 8'h20;
  localparam logic [7:0] OP_BLK32_ERS = 8'h52;
  localparam logic [7:0] OP_BLK64_ERS = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERS1 = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERS2 = 8'h60;
  localparam logic [7:0] OP_SUSPEND   = 8'h75;
  localparam logic [7:0] OP_RESUME    = 8'h7A;

  // ----------------------------------------------------------------
  // Frame lengths in link clocks
  // ----------------------------------------------------------------
  localparam logic [15:0] LEN_OPCODE    = 16'h0008;
  localparam logic [15:0] LEN_ERASE_A3  = 16'h0020;  // Opcode plus 24 serial address bits
  localparam logic [15:0] LEN_ERASE_A4  = 16'h0028;  // Opcode plus 32 serial address bits
  localparam logic [15:0] LEN_QADDR_A3  = 16'h000E;  // Opcode plus 6 address nibbles
  localparam logic [15:0] LEN_QADDR_A4  = 16'h0010;  // Opcode plus 8 address nibbles
  localparam logic [15:0] LEN_MAX       = 16'hFFFF;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int          PAGE_BYTES    = 256;
  localparam int          NUM_BLOCKS    = 512;
  localparam int          BLK_LSB       = 16;
  localparam int          BLK_MSB       = 24;
  localparam logic [8:0]  PAGE_FULL     = 9'h100;
  localparam logic [31:0] MASK_SECTOR   = 32'hFFFF_F000;
  localparam logic [31:0] MASK_BLK32    = 32'hFFFF_8000;
  localparam logic [31:0] MASK_BLK64    = 32'hFFFF_0000;
  localparam logic [31:0] MASK_PAGE     = 32'hFFFF_FF00;
  localparam logic [31:0] MASK_ADDR3    = 32'h00FF_FFFF;
  localparam logic [9:0]  BP_ALL        = 10'h200;
  localparam logic [3:0]  BP_ALL_CODE   = 4'hA;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_PERIOD_NS = 25;
  localparam int REF_CYCLES_PER_US = 1000 / REF_CLK_PERIOD_NS;
  localparam int RESUME_BUSY_NS    = 200;
  localparam int RESUME_CYCLES     = (RESUME_BUSY_NS / REF_CLK_PERIOD_NS < 1) ? 1 :
                                     RESUME_BUSY_NS / REF_CLK_PERIOD_NS;
  localparam int SUSPEND_LATENCY_US = 20;
  localparam int SUSPEND_CYCLES    = SUSPEND_LATENCY_US * REF_CYCLES_PER_US;
  localparam int PAGE_PROG_US      = 700;
  localparam int SECT_ERASE_US     = 45000;
  localparam int BLK32_ERASE_US    = 120000;
  localparam int BLK64_ERASE_US    = 150000;
  localparam int CHIP_ERASE_US     = 20000000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    K_SECTOR = 3'b000,
    K_BLK32  = 3'b001,
    K_BLK64  = 3'b010,
    K_CHIP   = 3'b011,
    K_PROG   = 3'b100
  } op_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE       = 3'b000,
    ST_WALK       = 3'b001,
    ST_RUN        = 3'b010,
    ST_SUSPENDING = 3'b011,
    ST_RESUMING   = 3'b100
  } seq_state_t;

endpackage

// [flash_pes_props.sv]
/*
  Checker for the program, erase and suspend sequencer.
  Assumes it is bound onto flash_pes and watches the core clock only.
*/
`timescale 1ns/10ps
module flash_pes_props
  import flash_pes_pkg::*;
(
  input wire logic                  ref_clk_i,
  input wire logic                  rst_i,
  input wire logic                  quad_enable_i,
  input wire logic                  protect_complement_i,
  input wire logic [3:0]            block_protect_i,
  input wire logic [NUM_BLOCKS-1:0] block_lock_i,
  input wire logic                  busy_o,
  input wire logic                  write_enable_latch_o,
  input wire logic                  suspend_flag_o,
  input wire logic                  status_write_ok_o,
  input wire logic                  arr_we_o,
  input wire logic [31:0]           arr_addr_o,
  input wire logic                  arr_erase_o,
  input wire logic [2:0]            arr_erase_kind_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // All checks on the core clock, quiet during reset
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  AST_PROG_QE: assert property (arr_we_o |-> quad_enable_i && write_enable_latch_o)
    else $error("program byte without quad enable or latch");
  AST_WE_BUSY: assert property (arr_we_o |-> busy_o)
    else $error("program byte outside busy");
  AST_ERASE_WEL: assert property (arr_erase_o |-> write_enable_latch_o && busy_o)
    else $error("erase without latch or busy");
  AST_SECT_ALIGN: assert property (arr_erase_o && arr_erase_kind_o == K_SECTOR |-> arr_addr_o[11:0] == 12'h000)
    else $error("sector erase address not aligned");
  AST_BLK64_ALIGN: assert property (arr_erase_o && arr_erase_kind_o == K_BLK64 |-> arr_addr_o[15:0] == 16'h0000)
    else $error("block erase address not aligned");
  AST_CHIP_FREE: assert property (arr_erase_o && arr_erase_kind_o == K_CHIP |-> !protect_complement_i && block_protect_i == 4'h0 && block_lock_i == '0)
    else $error("chip erase with protection set");
  AST_WEL_CLEAR: assert property ($fell(busy_o) && !suspend_flag_o |-> !write_enable_latch_o)
    else $error("latch not cleared at cycle end");
  AST_SUSP_BUSY: assert property ($rose(suspend_flag_o) |-> busy_o ##[1:810] !busy_o)
    else $error("busy not dropped after suspend");
  AST_RESUME_BUSY: assert property ($fell(suspend_flag_o) |-> !busy_o ##[1:9] busy_o)
    else $error("busy not raised after resume");
  AST_SR_WRITE: assert property (status_write_ok_o == !suspend_flag_o)
    else $error("status write permission wrong");
endmodule

bind flash_pes flash_pes_props u_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .quad_enable_i(quad_enable_i),
  .protect_complement_i(protect_complement_i), .block_protect_i(block_protect_i),
  .block_lock_i(block_lock_i), .busy_o(busy_o), .write_enable_latch_o(write_enable_latch_o),
  .suspend_flag_o(suspend_flag_o), .status_write_ok_o(status_write_ok_o),
  .arr_we_o(arr_we_o), .arr_addr_o(arr_addr_o), .arr_erase_o(arr_erase_o),
  .arr_erase_kind_o(arr_erase_kind_o)
);

// [spi_host_model.sv]
/*
  Host side of the serial link: sends whole command frames on a 64 ns clock.
  Assumes the caller waits for each frame to return before the next.
*/
`timescale 1ns/10ps
module spi_host_model
  import flash_pes_pkg::*;
(
  output logic       cs_n_o,
  output logic       spi_clk_o,
  output logic [3:0] io_o
);
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  // Idle: clock stands low, lines show no stale value
  initial begin
    cs_n_o    = 1'b1;
    spi_clk_o = 1'b0;
    io_o      = 4'h5;
  end

  // One link clock, data set mid low phase
  task automatic bit_out(input logic [3:0] v);
    io_o = v;
    #16 spi_clk_o = 1'b1;
    #32 spi_clk_o = 1'b0;
    #16;
  endtask

  // Serial bits on io0, MSB first
  task automatic ser(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) bit_out({{3{~v[i]}}, v[i]});
  endtask

  // Chip select low for the whole frame, up right after the last bit
  task automatic frame(input logic [7:0] op, input int na, input logic [31:0] a,
                       input int nb, input logic [7:0] d, input int ex);
    logic [7:0] b;
    cs_n_o = 1'b0;
    #20;
    ser({24'h0, op}, 8);
    if (op == OP_QUAD_PROG) begin
      for (int i = na - 4; i >= 0; i -= 4) bit_out(a[i+:4]);
      for (int k = 0; k < nb; k++) begin
        b = d + 8'(k);
        bit_out(b[7:4]);
        bit_out(b[3:0]);
      end
    end else begin
      ser(a, na);
    end
    repeat (ex) bit_out(4'h0);
    #16 cs_n_o = 1'b1;
    io_o = ~io_o;
    #400;
  endtask
endmodule

// [tb_flash_pes.sv]
/*
  Self-checking bench of the sequencer.
  Assumes the host model drives the link and the bench drives the rest.
*/
`timescale 1ns/10ps
module tb_flash_pes;
  import flash_pes_pkg::*;
  logic ref_clk_i, rst_i, cs_n, spi_clk, qe, a4, cmp, tb, busy, write_enable_latch, suspend_flag, swok, we, er;
  logic [3:0]            io, bp;
  logic [NUM_BLOCKS-1:0] lock;
  logic [31:0]           addr, wa[$], ea[$];
  logic [7:0]            wdat, wd[$];
  logic [2:0]            kind, ek[$];
  int                    n_errors, n_tests, cyc;

  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  flash_pes #(.PROG_CYCLES(30), .SECT_CYCLES(30), .BLK32_CYCLES(40), .BLK64_CYCLES(80),
    .CHIP_CYCLES(80)) u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .spi_clk_i(spi_clk),
    .cs_n_i(cs_n), .io_i(io), .quad_enable_i(qe), .addr4_mode_i(a4),
    .protect_complement_i(cmp), .protect_top_bottom_i(tb), .block_protect_i(bp),
    .block_lock_i(lock), .busy_o(busy), .write_enable_latch_o(write_enable_latch), .suspend_flag_o(suspend_flag),
    .status_write_ok_o(swok), .arr_we_o(we), .arr_addr_o(addr), .arr_wdata_o(wdat),
    .arr_erase_o(er), .arr_erase_kind_o(kind));
  spi_host_model u_host (.cs_n_o(cs_n), .spi_clk_o(spi_clk), .io_o(io));

  // Reference clock, 25 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // Array traffic log and hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (we === 1'b1) begin
      wa.push_back(addr);
      wd.push_back(wdat);
    end
    if (er === 1'b1) begin
      ea.push_back(addr);
      ek.push_back(kind);
    end
    if (cyc == 60000) begin
      n_errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] op, input int na = 0, input logic [31:0] a = 0,
                     input int nb = 0, input int ex = 0);
    u_host.frame(op, na, a, nb, 8'hA0, ex);
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge ref_clk_i);
  endtask

  task automatic reset(input int n);
    @(posedge ref_clk_i) #1 rst_i = 1'b1;
    repeat (n) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Latch and quad enable gating, then page wrap
  task automatic s_prog;
    @(posedge ref_clk_i) #1 qe = 1'b1;
    cmd(OP_QUAD_PROG, 24, 32'h0000_10FE, 1);
    check(32'(wa.size()), 32'h0000_0000);
    @(posedge ref_clk_i) #1 qe = 1'b0;
    cmd(OP_WR_EN);
    cmd(OP_QUAD_PROG, 24, 32'h0000_10FE, 1);
    check(32'(wa.size()), 32'h0000_0000);
    @(posedge ref_clk_i) #1 qe = 1'b1;
    cmd(OP_QUAD_PROG, 24, 32'h0000_10FE, 3);
    wait_idle();
    check(32'(wa.size()), 32'h0000_0003);
    check(wa[2], 32'h0000_1000);
    check(32'(wd[2]), 32'h0000_00A2);
    check(32'(write_enable_latch), 32'h0000_0000);
  endtask

  // Erase units, alignment, wide address and a frame one bit too long
  task automatic s_erase;
    logic [7:0]  ops[3];
    logic [31:0] al[3];
    ops = '{OP_SECT_ERS, OP_BLK32_ERS, OP_BLK64_ERS};
    al  = '{32'h0012_3000, 32'h0012_0000, 32'h0012_0000};
    for (int i = 0; i < 3; i++) begin
      cmd(OP_WR_EN);
      cmd(ops[i], 24, 32'h0012_3456);
      wait_idle();
      check(ea[$], al[i]);
      check(32'(ek[$]), 32'(i));
    end
    @(posedge ref_clk_i) #1 a4 = 1'b1;
    cmd(OP_WR_EN);
    cmd(OP_SECT_ERS, 32, 32'h0123_4567);
    wait_idle();
    check(ea[$], 32'h0123_4000);
    @(posedge ref_clk_i) #1 a4 = 1'b0;
    cmd(OP_WR_EN);
    cmd(OP_SECT_ERS, 24, 32'h0000_4000, 0, 1);
    check(32'(ea.size()), 32'h0000_0004);
  endtask

  // Both chip erase codes, then protected targets refused
  task automatic s_chip;
    logic [7:0] ops[2];
    ops = '{OP_CHIP_ERS1, OP_CHIP_ERS2};
    for (int i = 0; i < 2; i++) begin
      cmd(OP_WR_EN);
      cmd(ops[i]);
      wait_idle();
      check(32'(ek[$]), 32'(K_CHIP));
    end
    @(posedge ref_clk_i) #1 bp = 4'h1;
    tb = 1'b1;
    cmd(OP_WR_EN);
    cmd(OP_CHIP_ERS1);
    cmd(OP_SECT_ERS, 24, 32'h0000_1000);
    check(32'(ea.size()), 32'h0000_0006);
    @(posedge ref_clk_i) #1 bp = 4'h0;
    lock[3] = 1'b1;
    cmd(OP_SECT_ERS, 24, 32'h0003_0000);
    check(32'(ea.size()), 32'h0000_0006);
    @(posedge ref_clk_i) #1 lock = '0;
  endtask

  // Suspend, refused erase, resume, ignored suspends, reset
  task automatic s_susp;
    cmd(OP_WR_EN);
    cmd(OP_BLK64_ERS, 24, 32'h0002_0000);
    cmd(OP_SUSPEND);
    check(32'(suspend_flag), 32'h0000_0001);
    check(32'(swok), 32'h0000_0000);
    wait_idle();
    cmd(OP_WR_EN);
    cmd(OP_SECT_ERS, 24, 32'h0000_5000);
    check(32'(ea.size()), 32'h0000_0007);
    cmd(OP_RESUME);
    check({31'h0, suspend_flag}, 32'h0000_0000);
    check({31'h0, busy}, 32'h0000_0001);
    wait_idle();
    check({31'h0, busy}, 32'h0000_0000);
    cmd(OP_SUSPEND);
    check({31'h0, suspend_flag}, 32'h0000_0000);
    cmd(OP_WR_EN);
    cmd(OP_CHIP_ERS2);
    cmd(OP_SUSPEND);
    check({31'h0, suspend_flag}, 32'h0000_0000);
    wait_idle();
    cmd(OP_WR_EN);
    cmd(OP_BLK64_ERS, 24, 32'h0006_0000);
    cmd(OP_SUSPEND);
    check({31'h0, suspend_flag}, 32'h0000_0001);
    reset(3);
    check({30'h0, suspend_flag, busy}, 32'h0000_0000);
  endtask

  task automatic test_done;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_i, qe, a4, cmp, tb, bp, lock} = '0;
    rst_i = 1'b1;
    repeat (16) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    s_prog();
    s_erase();
    s_chip();
    s_susp();
    test_done();
  end
endmodule
